// file: common/lmg_pkg.sv
// Shared constants for the linked-move gearbox block
package lmg_pkg;
    localparam int NAXES = 8;
    localparam int AXW = 3;
    localparam int PW = 32;
    localparam int UW = 16;
    localparam int FRAC = 16;
    localparam int DIV_STEPS = 64;
    // Start option encoding
    localparam logic [2:0] OPT_REG_START = 3'h1;
    localparam logic [2:0] OPT_POS_START = 3'h2;
    localparam int OPT_REPEAT_BIT = 2;
    localparam int REP_CANCEL_BIT = 1;
    // Next-move kind codes (link code is arbitrary)
    localparam logic [7:0] KIND_NONE = 8'h00;
    localparam logic [7:0] KIND_LINK = 8'h0A;
    // Reset values
    localparam logic [PW-1:0] RST_POS = 32'h0000_0000;
    localparam logic [63:0] RST_ACC = 64'h0;
    typedef enum {SU_IDLE, SU_SCALE, SU_V, SU_KA, SU_KD} lmg_su_t;
    typedef enum {RN_IDLE, RN_ARM, RN_RUN} lmg_rn_t;
endpackage

// file: core/lmg_div.sv
// Sequential restoring divider, 64-bit by 32-bit
module lmg_div
    import lmg_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [63:0] dividend,
    input  wire logic [31:0] divisor,
    output logic             busy,
    output logic             done,
    output logic [63:0]      quotient
);
    logic [32:0] rem;
    logic [6:0]  cnt;
    logic [32:0] trial;

    // Shift in next dividend bit
    assign trial = {rem[31:0], quotient[63]};

    // ----------------------------------------
    // Iteration: one quotient bit per clock
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rem      <= 33'h0;
            quotient <= 64'h0;
            cnt      <= 7'h00;
            busy     <= 1'b0;
            done     <= 1'b0;
        end
        else if (start && !busy)
        begin
            rem      <= 33'h0;
            quotient <= dividend;
            cnt      <= 7'(DIV_STEPS);
            busy     <= 1'b1;
            done     <= 1'b0;
        end
        else if (busy)
        begin
            if (trial >= {1'b0, divisor})
            begin
                rem      <= trial - {1'b0, divisor};
                quotient <= {quotient[62:0], 1'b1};
            end
            else
            begin
                rem      <= trial;
                quotient <= {quotient[62:0], 1'b0};
            end
            cnt  <= cnt - 7'h01;
            busy <= (cnt != 7'h01);
            done <= (cnt == 7'h01);
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule

// file: core/lmg_core.sv
// Linked-move profile generator driven by a link axis position
//
// Operation
// RULE1: Follower progress follows link axis measured travel, not time.
// RULE2: Link span split into accel, constant and decel phases.
// RULE3: Constant span equals total span minus both ramp spans.
// RULE4: Follower ramps up over accel span, down over decel span.
// RULE5: Oversized ramp spans shrink proportionally to fit total span.
// RULE6: Spans positive; link travel in either direction drives follower.
// RULE7: Follower distance is incremental, complete when full span measured.
// RULE8: Option 1 waits for registration event on link axis.
// RULE9: Option 2 waits for link axis to reach absolute start position.
// RULE10: Option 4 repeats move; repeat control bit 1 cancels it.
// RULE11: Option 5 is registration plus repeat, 6 is position plus repeat.
// RULE12: Issuer uses link span twice distance for matched-speed ramp.
// RULE13: Issuer uses equal distance and span for matched constant speed.
// RULE14: Consecutive moves join seamlessly, equal to one summed move.
// RULE15: Next-move kind reads zero once the next-move slot is empty.
// RULE16: Axis select and unit factors apply as for other moves.
// RULE17: Ramp ratio varies linearly with link travel, zero to plateau.
module lmg_core
    import lmg_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    input  wire logic signed [PW-1:0] cmd_distance,
    input  wire logic [PW-1:0]        cmd_link_dist,
    input  wire logic [PW-1:0]        cmd_link_acc,
    input  wire logic [PW-1:0]        cmd_link_dec,
    input  wire logic [AXW-1:0]       cmd_link_axis,
    input  wire logic [2:0]           cmd_link_option,
    input  wire logic signed [PW-1:0] cmd_link_pos,
    input  wire logic [UW-1:0]        units_follow,
    input  wire logic [UW-1:0]        units_link,
    input  wire logic signed [PW-1:0] axis_pos [NAXES],
    input  wire logic [NAXES-1:0]     regist_pin,
    input  wire logic [7:0]           wrap_repeat_control,
    output logic signed [PW-1:0]      follow_pos,
    output logic                      move_active,
    output logic [7:0]                next_move_kind
);
    lmg_su_t su;
    lmg_rn_t rn;
    logic signed [PW-1:0] s_d, n_d, a_d;
    logic [PW-1:0] s_l, s_a, s_dd, n_l, n_a, n_dd, a_l, a_a, a_dd;
    logic [PW-1:0] s_v, n_v, a_v;
    logic [63:0] s_ka, n_ka, n_kd, a_ka, a_kd;
    logic [AXW-1:0] s_ax, n_ax, a_ax;
    logic [2:0] s_opt, n_opt, a_opt;
    logic signed [PW-1:0] s_sp, n_sp, a_sp;
    logic n_full;
    logic su_fin;
    logic dv_go, dv_issued, dv_busy, dv_done;
    logic [63:0] dv_num, dv_q;
    logic [31:0] dv_den;
    logic [NAXES-1:0] reg_s1, reg_s2, reg_s3;
    logic signed [PW-1:0] prev, base;
    logic [PW-1:0] t;
    logic [63:0] acc;
    logic signed [PW:0] dlt;
    logic [PW-1:0] dt, r, mag, d_abs;
    logic [PW:0] tn;
    logic [63:0] inc, rmul;
    logic reg_hit, pos_hit, start_hit, repeat_on;
    logic [PW:0] ramp_sum;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Async pins; third stage gives edge history
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            reg_s1 <= '0;
            reg_s2 <= '0;
            reg_s3 <= '0;
        end
        else
        begin
            reg_s1 <= regist_pin;
            reg_s2 <= reg_s1;
            reg_s3 <= reg_s2;
        end
    end

    // ----------------------------------------
    // Command setup: scale and precompute
    // ----------------------------------------
    assign cmd_ready = (su == SU_IDLE) && !n_full;
    assign ramp_sum = {1'b0, s_a} + {1'b0, s_dd};
    assign d_abs = s_d[PW-1] ? PW'(-s_d) : PW'(s_d);

    // Divider operands per setup step
    always_comb
    begin
        dv_num = 64'h0;
        dv_den = 32'h1;
        case (su)
            SU_SCALE:
            begin
                dv_num = 64'(s_a) * 64'(s_l);
                dv_den = ramp_sum[PW-1:0];
            end
            SU_V:
            begin
                dv_num = {16'h0, d_abs, 16'h0};
                dv_den = s_l - 32'(ramp_sum >> 1); // see RULE3
                if (dv_den == 32'h0)
                begin
                    dv_den = 32'h1;
                end
            end
            SU_KA:
            begin
                dv_num = {16'h0, s_v, 16'h0};
                dv_den = s_a;
            end
            SU_KD:
            begin
                dv_num = {16'h0, s_v, 16'h0};
                dv_den = s_dd;
            end
            default:
            begin
                dv_num = 64'h0;
                dv_den = 32'h1;
            end
        endcase
    end

    assign dv_go = !dv_issued && !dv_busy &&
                   ((su == SU_SCALE && ramp_sum > {1'b0, s_l}) ||
                    su == SU_V || (su == SU_KA && s_a != 32'h0) ||
                    (su == SU_KD && s_dd != 32'h0));
    assign su_fin = (su == SU_KD) && (dv_done || s_dd == 32'h0);

    lmg_div u_div (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .start    (dv_go),
        .dividend (dv_num),
        .divisor  (dv_den),
        .busy     (dv_busy),
        .done     (dv_done),
        .quotient (dv_q)
    );

    // Setup sequencer; unit factors scale arguments on intake
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            su        <= SU_IDLE;
            dv_issued <= 1'b0;
            s_d  <= RST_POS;
            s_l  <= RST_POS;
            s_a  <= RST_POS;
            s_dd <= RST_POS;
            s_v  <= RST_POS;
            s_ka <= RST_ACC;
            s_ax <= '0;
            s_opt <= '0;
            s_sp <= RST_POS;
        end
        else
        begin
            dv_issued <= dv_done ? 1'b0 : (dv_issued | dv_go);
            case (su)
                SU_IDLE:
                begin
                    if (cmd_valid && cmd_ready)
                    begin
                        s_d  <= PW'(cmd_distance * $signed({1'b0,
                                units_follow}));      // see RULE16
                        s_l  <= PW'(cmd_link_dist * units_link);
                        s_a  <= PW'(cmd_link_acc * units_link);
                        s_dd <= PW'(cmd_link_dec * units_link);
                        s_sp <= PW'(cmd_link_pos * $signed({1'b0,
                                units_link}));
                        s_ax <= cmd_link_axis;       // see RULE16
                        s_opt <= cmd_link_option;
                        su   <= SU_SCALE;
                    end
                end
                SU_SCALE:
                begin
                    // Oversized ramps shrink in proportion
                    if (ramp_sum <= {1'b0, s_l})
                    begin
                        su <= SU_V;
                    end
                    else if (dv_done)
                    begin
                        s_a  <= dv_q[PW-1:0];        // see RULE5
                        s_dd <= s_l - dv_q[PW-1:0];  // see RULE5
                        su   <= SU_V;
                    end
                end
                SU_V:
                begin
                    // Plateau ratio so area under ratio equals distance
                    if (dv_done)
                    begin
                        s_v <= dv_q[PW-1:0];         // see RULE7
                        su  <= SU_KA;
                    end
                end
                SU_KA:
                begin
                    if (s_a == 32'h0 || dv_done)
                    begin
                        s_ka <= (s_a == 32'h0) ? RST_ACC : dv_q;
                        su   <= SU_KD;
                    end
                end
                SU_KD:
                begin
                    if (su_fin)
                    begin
                        su <= SU_IDLE;
                    end
                end
                default: su <= SU_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Next-move slot
    // ----------------------------------------
    // Filled ahead so the following move starts without a gap
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            n_full <= 1'b0;
            n_d <= RST_POS;
            n_l <= RST_POS;
            n_a <= RST_POS;
            n_dd <= RST_POS;
            n_v <= RST_POS;
            n_ka <= RST_ACC;
            n_kd <= RST_ACC;
            n_ax <= '0;
            n_opt <= '0;
            n_sp <= RST_POS;
        end
        else if (su_fin)
        begin
            n_full <= 1'b1;
            n_d <= s_d;
            n_l <= s_l;
            n_a <= s_a;
            n_dd <= s_dd;
            n_v <= s_v;
            n_ka <= s_ka;
            n_kd <= (s_dd == 32'h0) ? RST_ACC : dv_q;
            n_ax <= s_ax;
            n_opt <= s_opt;
            n_sp <= s_sp;
        end
        else if (n_full && (rn == RN_IDLE || (rn == RN_RUN &&
                 tn >= {1'b0, a_l} && !repeat_on)))
        begin
            n_full <= 1'b0;
        end
    end

    // Kind code reflects slot occupancy
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            next_move_kind <= KIND_NONE;
        end
        else
        begin
            next_move_kind <= n_full ? KIND_LINK : KIND_NONE; // see RULE15
        end
    end

    // ----------------------------------------
    // Link tracking and follower profile
    // ----------------------------------------
    // Absolute step of link axis, sign ignored
    assign dlt = {axis_pos[a_ax][PW-1], axis_pos[a_ax]} - {prev[PW-1], prev};
    assign dt = dlt[PW] ? PW'(-dlt) : PW'(dlt);         // see RULE6
    assign tn = {1'b0, t} + {1'b0, dt};
    assign repeat_on = a_opt[OPT_REPEAT_BIT] &&
                       !wrap_repeat_control[REP_CANCEL_BIT]; // see RULE10
    assign reg_hit = reg_s2[a_ax] && !reg_s3[a_ax];   // see RULE8
    assign pos_hit = (prev <= a_sp && axis_pos[a_ax] >= a_sp) ||
                     (prev >= a_sp && axis_pos[a_ax] <= a_sp); // see RULE9
    assign start_hit = ((a_opt[1:0] == OPT_REG_START[1:0]) && reg_hit) ||
                       ((a_opt[1:0] == OPT_POS_START[1:0]) && pos_hit);

    // Ratio at mid-step keeps ramp area exact; flat plateau
    always_comb
    begin
        rmul = 64'h0;
        if (t < a_a)
        begin
            rmul = 64'({1'b0, t, 1'b0} + {2'b0, dt}) * a_ka; // see RULE17
            r = rmul[FRAC+PW:FRAC+1];
        end
        else if (t < a_l - a_dd)
        begin
            r = a_v;                                   // see RULE2
        end
        else
        begin
            rmul = 64'({1'b0, PW'(a_l - t), 1'b0} - {2'b0, dt}) *
                   a_kd;                               // see RULE4
            r = rmul[FRAC+PW:FRAC+1];
        end
        inc = 64'(r) * 64'(dt);                        // see RULE1
    end

    assign mag = (acc[FRAC+PW-1:FRAC] > PW'(a_d[PW-1] ? -a_d : a_d)) ?
                 PW'(a_d[PW-1] ? -a_d : a_d) : acc[FRAC+PW-1:FRAC];

    // Move sequencer; end snaps to exact distance, overshoot carried
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rn <= RN_IDLE;
            a_d <= RST_POS;
            a_l <= RST_POS;
            a_a <= RST_POS;
            a_dd <= RST_POS;
            a_v <= RST_POS;
            a_ka <= RST_ACC;
            a_kd <= RST_ACC;
            a_ax <= '0;
            a_opt <= '0;
            a_sp <= RST_POS;
            prev <= RST_POS;
            base <= RST_POS;
            t <= RST_POS;
            acc <= RST_ACC;
        end
        else
        begin
            prev <= axis_pos[a_ax];
            case (rn)
                RN_IDLE:
                begin
                    if (n_full)
                    begin
                        a_d <= n_d;
                        a_l <= n_l;
                        a_a <= n_a;
                        a_dd <= n_dd;
                        a_v <= n_v;
                        a_ka <= n_ka;
                        a_kd <= n_kd;
                        a_ax <= n_ax;
                        a_opt <= n_opt;
                        a_sp <= n_sp;
                        prev <= axis_pos[n_ax];
                        t <= RST_POS;
                        acc <= RST_ACC;
                        rn <= (n_opt[1:0] != 2'h0) ? RN_ARM : RN_RUN;
                    end
                end
                RN_ARM:
                begin
                    // Link travel before the trigger is not counted
                    if (start_hit)
                    begin
                        rn <= RN_RUN;                  // see RULE11
                    end
                end
                RN_RUN:
                begin
                    if (tn >= {1'b0, a_l})
                    begin
                        base <= base + a_d;            // see RULE7
                        acc <= RST_ACC;
                        if (repeat_on)
                        begin
                            t <= (a_opt[1:0] != 2'h0) ? RST_POS :
                                 PW'(tn - {1'b0, a_l});
                            rn <= (a_opt[1:0] != 2'h0) ? RN_ARM : RN_RUN;
                        end
                        else if (n_full)
                        begin
                            a_d <= n_d;
                            a_l <= n_l;
                            a_a <= n_a;
                            a_dd <= n_dd;
                            a_v <= n_v;
                            a_ka <= n_ka;
                            a_kd <= n_kd;
                            a_ax <= n_ax;
                            a_opt <= n_opt;
                            a_sp <= n_sp;
                            prev <= axis_pos[n_ax];
                            t <= (n_opt[1:0] != 2'h0) ? RST_POS :
                                 PW'(tn - {1'b0, a_l}); // see RULE14
                            rn <= (n_opt[1:0] != 2'h0) ? RN_ARM : RN_RUN;
                        end
                        else
                        begin
                            t <= RST_POS;
                            rn <= RN_IDLE;
                        end
                    end
                    else
                    begin
                        t <= tn[PW-1:0];
                        acc <= acc + inc;
                    end
                end
                default: rn <= RN_IDLE;
            endcase
        end
    end

    // Follower demand, clamped to the commanded distance
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            follow_pos <= RST_POS;
            move_active <= 1'b0;
        end
        else
        begin
            follow_pos <= a_d[PW-1] ? base - $signed(mag) :
                          base + $signed(mag);
            move_active <= (rn != RN_IDLE);
        end
    end
endmodule

// file: verification/lmg_monitor.sv
// Port-level checker for the gearbox core
module lmg_monitor
    import lmg_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 cmd_valid,
    input  wire logic                 cmd_ready,
    input  wire logic signed [PW-1:0] axis_pos [NAXES],
    input  wire logic signed [PW-1:0] follow_pos,
    input  wire logic                 move_active,
    input  wire logic [7:0]           next_move_kind
);
    logic signed [PW-1:0] prev_pos [NAXES];
    logic                 moved;

    // Step flag, one edge late to match follower latency
    always_ff @(posedge clk_sys)
    begin
        prev_pos <= axis_pos;
        moved <= (prev_pos != axis_pos);
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_reset_clear: assert property (
        $rose(rst_n) |-> follow_pos == 0 && !move_active
        && next_move_kind == KIND_NONE && cmd_ready)
        else $error("reset values wrong");
    chk_idle_hold: assert property (
        $changed(follow_pos) |->
        move_active || $past(move_active) || $past(move_active, 2))
        else $error("moved while idle");
    chk_travel_only: assert property (
        $changed(follow_pos) |-> moved || $past(moved)
        || $past(moved, 2) || $past(moved, 3))
        else $error("moved without travel");
    chk_kind_code: assert property (
        next_move_kind == KIND_NONE || next_move_kind == KIND_LINK)
        else $error("bad kind code");
    chk_full_blocks: assert property (
        cmd_ready |=> next_move_kind == KIND_NONE)
        else $error("ready with slot full");
    chk_accept_busy: assert property (
        cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("ready after accept");
    chk_setup_bound: assert property (
        cmd_valid && cmd_ready |->
        ##[1:400] (next_move_kind == KIND_LINK || move_active))
        else $error("move never queued");
    chk_load_runs: assert property (
        $fell(next_move_kind == KIND_LINK) && $past(rst_n) |->
        ##[0:2] move_active)
        else $error("load without move");

    cov_accept: cover property (cmd_valid && cmd_ready);
    cov_slot_full: cover property (next_move_kind == KIND_LINK
        && move_active);
    cov_move_end: cover property ($fell(move_active));
endmodule

bind lmg_core lmg_monitor mon (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .axis_pos(axis_pos),
    .follow_pos(follow_pos), .move_active(move_active),
    .next_move_kind(next_move_kind));

// file: verification/lmg_enc_model.sv
// Link axis encoder and registration sensor model
module lmg_enc_model
    import lmg_pkg::*;
(
    input  wire logic            clk_sys,
    output logic signed [PW-1:0] axis_pos [NAXES],
    output logic [NAXES-1:0]     regist_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // Distinct origins expose a wrong axis index
    initial
    begin
        foreach (axis_pos[i])
            axis_pos[i] = 32'(i * 1000);
        regist_pin = '0;
    end

    // ----------------------------------------
    // Motion tasks
    // ----------------------------------------
    // k counts per cycle on one axis, either sign
    task automatic travel(input int ax, input int k, input int n);
        repeat (n)
        begin
            @(negedge clk_sys);
            axis_pos[ax] <= axis_pos[ax] + k;
        end
    endtask

    // Pulse long enough for the two-stage synchroniser
    task automatic mark(input int ax);
        @(negedge clk_sys);
        regist_pin[ax] <= 1'b1;
        repeat (6) @(negedge clk_sys);
        regist_pin[ax] <= 1'b0;
    endtask
endmodule

// file: verification/test_linked_move_gearbox.sv
// Self-checking bench for the gearbox core
module test_linked_move_gearbox
    import lmg_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clk_sys = 1'b0;
    logic                 rst_n;
    logic                 cmd_valid;
    logic                 cmd_ready;
    logic signed [PW-1:0] cmd_distance;
    logic [PW-1:0]        cmd_link_dist;
    logic [PW-1:0]        cmd_link_acc;
    logic [PW-1:0]        cmd_link_dec;
    logic [AXW-1:0]       cmd_link_axis;
    logic [2:0]           cmd_link_option;
    logic signed [PW-1:0] cmd_link_pos;
    logic [UW-1:0]        units_follow;
    logic [UW-1:0]        units_link;
    logic signed [PW-1:0] axis_pos [NAXES];
    logic [NAXES-1:0]     regist_pin;
    logic [7:0]           wrap_repeat_control;
    logic signed [PW-1:0] follow_pos;
    logic                 move_active;
    logic [7:0]           next_move_kind;
    int                   num_errors = 0;
    int                   cmp_count = 0;
    int                   base = 0;

    // 10 MHz servo clock
    always #50 clk_sys = ~clk_sys;

    lmg_core dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_distance(cmd_distance),
        .cmd_link_dist(cmd_link_dist), .cmd_link_acc(cmd_link_acc),
        .cmd_link_dec(cmd_link_dec), .cmd_link_axis(cmd_link_axis),
        .cmd_link_option(cmd_link_option), .cmd_link_pos(cmd_link_pos),
        .units_follow(units_follow), .units_link(units_link),
        .axis_pos(axis_pos), .regist_pin(regist_pin),
        .wrap_repeat_control(wrap_repeat_control),
        .follow_pos(follow_pos), .move_active(move_active),
        .next_move_kind(next_move_kind)
    );
    lmg_enc_model enc (
        .clk_sys(clk_sys), .axis_pos(axis_pos), .regist_pin(regist_pin)
    );

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // Two counts of fixed-point slack
    function automatic logic [31:0] near(input int e);
        return {31'h0, follow_pos - e <= 2 && e - follow_pos <= 2};
    endfunction

    // Offer held until ready, then wait for arm or run
    task automatic issue(input int d, input int s, input int a,
                         input int e, input logic [2:0] op, input int p);
        @(negedge clk_sys);
        cmd_distance = d;
        cmd_link_dist = s;
        cmd_link_acc = a;
        cmd_link_dec = e;
        cmd_link_option = op;
        cmd_link_pos = p;
        cmd_valid = 1'b1;
        for (int i = 0; i < 2000 && cmd_ready !== 1'b1; i++)
            @(negedge clk_sys);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd_distance = ~cmd_distance;
        cmd_link_pos = ~cmd_link_pos;
        for (int i = 0; i < 1000 && move_active !== 1'b1; i++)
            @(negedge clk_sys);
    endtask

    // Travel, then let the two-cycle latency pass
    task automatic run(input int k, input int n);
        enc.travel(3, k, n);
        repeat (4) @(negedge clk_sys);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk(next_move_kind, KIND_NONE);
        chk(cmd_ready, 32'h1);
        chk(follow_pos, 32'h0);
    endtask

    task automatic t_plateau;
        issue(1000, 1000, 0, 0, 3'h0, 0);
        run(5, 100);
        chk(near(base + 500), 32'h1);
        run(5, 100);
        base += 1000;
        chk(follow_pos, base);
        chk(move_active, 32'h0);
    endtask

    // Oversized ramps, reverse link travel
    task automatic t_scale;
        issue(-800, 400, 400, 400, 3'h0, 0);
        run(-5, 20);
        chk(near(base - 100), 32'h1);
        run(-5, 20);
        chk(near(base - 400), 32'h1);
        run(-5, 40);
        base -= 800;
        chk(follow_pos, base);
    endtask

    task automatic t_units;
        units_follow = 16'h0002;
        units_link = 16'h0003;
        issue(100, 50, 0, 0, 3'h0, 0);
        run(3, 49);
        chk(move_active, 32'h1);
        run(3, 1);
        base += 200;
        chk(follow_pos, base);
        units_follow = 16'h0001;
        units_link = 16'h0001;
    endtask

    task automatic t_start;
        issue(200, 100, 0, 0, 3'h1, 0);
        run(5, 20);
        chk(follow_pos, base);
        enc.mark(3);
        run(5, 20);
        base += 200;
        chk(follow_pos, base);
        issue(200, 100, 0, 0, 3'h2, axis_pos[3] + 100);
        run(5, 10);
        chk(follow_pos, base);
        run(5, 30);
        base += 200;
        chk(follow_pos, base);
    endtask

    // Accel move queued ahead of plateau-and-decel
    task automatic t_queue;
        issue(300, 600, 600, 0, 3'h0, 0);
        issue(700, 1000, 0, 600, 3'h0, 0);
        for (int i = 0; i < 900 && next_move_kind !== KIND_LINK; i++)
            @(negedge clk_sys);
        chk(next_move_kind, KIND_LINK);
        run(5, 60);
        chk(near(base + 75), 32'h1);
        run(5, 60);
        chk(next_move_kind, KIND_NONE);
        chk(follow_pos, base + 300);
        run(5, 200);
        base += 1000;
        chk(follow_pos, base);
    endtask

    // Cancel before the third pass ends the repeat
    task automatic t_repeat;
        for (int j = 4; j < 6; j++)
        begin
            wrap_repeat_control = 8'h00;
            issue(100, 100, 0, 0, 3'(j), 0);
            for (int r = 0; r < 3; r++)
            begin
                if (j == 5)
                    enc.mark(3);
                wrap_repeat_control = (r == 2) ? 8'h02 : 8'h00;
                run(5, 20);
            end
            base += 300;
            chk(follow_pos, base);
            chk(move_active, 32'h0);
        end
        wrap_repeat_control = 8'h00;
        issue(100, 100, 0, 0, 3'h6, axis_pos[3] + 50);
        run(5, 30);
        base += 100;
        chk(follow_pos, base);
        chk(move_active, 32'h1);
    endtask

    task automatic complete_run;
        $display("cmp=%0d err=%0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Axis 3 links throughout
    initial
    begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_distance = '0;
        cmd_link_dist = '0;
        cmd_link_acc = '0;
        cmd_link_dec = '0;
        cmd_link_axis = 3'h3;
        cmd_link_option = 3'h0;
        cmd_link_pos = '0;
        units_follow = 16'h0001;
        units_link = 16'h0001;
        wrap_repeat_control = 8'h00;
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_plateau();
        t_scale();
        t_units();
        t_start();
        t_queue();
        t_repeat();
        complete_run();
    end

    // Hang guard, several times the run length
    initial
    begin
        #3ms;
        num_errors++;
        complete_run();
    end
endmodule
